// ### cis_pkg.sv
// shared constants and carrier types of the interrupt sequencer
`default_nettype none
package cis_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_FLAG_EN  = 8'h04;
  localparam logic [7:0] OFS_FLAG     = 8'h08;
  localparam logic [7:0] OFS_LEVEL_EN = 8'h0c;
  localparam logic [7:0] OFS_LEVEL    = 8'h10;
  localparam logic [7:0] OFS_SP       = 8'h14;
  localparam logic [7:0] OFS_STATUS   = 8'h18;
  // core_control_register / status_register fields
  localparam int CTRL_GIE_BIT   = 0;
  localparam int CTRL_VECTOR_TABLE_SELECT_BIT = 1;
  // status word fields
  localparam int STAT_IDX_LSB   = 0;
  localparam int STAT_STATE_LSB = 8;
  localparam int STAT_SKIP_BIT  = 12;
  localparam int STAT_FUSE_BIT  = 13;
  localparam int STAT_LOCKA_BIT = 14;
  localparam int STAT_LOCKB_BIT = 15;
  // reset values
  localparam logic [15:0] SP_RESET  = 16'h0000;
  localparam logic [15:0] PC_RESET  = 16'h0000;
  // timing counts in cpu clock cycles, vector stride and ahb-lite nonseq transfer code
  localparam logic [2:0] ENTRY_CYC   = 3'h4;
  localparam logic [2:0] JUMP_CYC    = 3'h3;
  localparam logic [2:0] RET_CYC     = 3'h4;
  localparam logic [2:0] WAKE_EXTRA  = 3'h4;
  localparam logic [2:0] RST_SETTLE  = 3'h3;
  localparam logic [15:0] VEC_STRIDE = 16'h0002;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic boundary;   // an instruction completes this cycle
    logic cli;        // completing instruction clears global enable
    logic sei;        // completing instruction sets global enable
    logic return_from_interrupt;       // return_from_interrupt is being executed
    logic sleeping;   // core sleeps
  } cis_core_t;

  typedef struct packed {
    logic        we;
    logic        re;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } cis_stk_t;
endpackage : cis_pkg
`default_nettype wire

// ### cis_sequencer.sv
// reset and interrupt sequencer of the cpu core with an ahb-lite register slave
`default_nettype none
module cis_sequencer
  import cis_pkg::*;
#(
  parameter int          NF         = 8,
  parameter int          NL         = 4,
  parameter logic [15:0] BOOT_START = 16'h7000
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire logic [NF-1:0]     flag_evt,
  input  wire logic [NL-1:0]     level_req,
  input  wire logic              boot_reset_fuse,
  input  wire logic              app_boot_lock_setting,
  input  wire logic              boot_section_lock_setting,
  input  wire cis_pkg::cis_core_t core,
  input  wire logic [15:0]       core_pc,
  input  wire logic [7:0]        stk_rdata,
  output logic                   core_hold,
  output logic                   pc_load,
  output logic [15:0]            pc_value,
  output cis_pkg::cis_stk_t      stk,
  output logic                   wake_req,
  output logic                   int_ack
);
  import cis_pkg::*;

  localparam int NT = NF + NL;

  // refuse source counts that the 8-bit index and 32-bit register words cannot hold
  if (NF < 1 || NL < 1 || NT > 32) begin : g_bad_counts
    $error("cis_sequencer: source counts out of range");
  end

  typedef enum {ST_RST, ST_IDLE, ST_WAKE, ST_ENTRY, ST_JUMP, ST_RET} cis_state_t;

  cis_state_t    st;
  logic [2:0]    cnt;
  logic [7:0]    act_idx;
  logic [15:0]   ret_pc;
  logic [7:0]    pop_hi;
  logic          i_bit;
  logic          vector_table_select;
  logic          skip;
  logic [NF-1:0] flag_en;
  logic [NF-1:0] flag_pend;
  logic [NL-1:0] lvl_en;
  logic [15:0]   sp;
  logic [2:0]    pin_s1;
  logic [2:0]    pin_s2;
  logic          ph_wr;
  logic [7:0]    ph_addr;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers for fuse and lock straps

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
    end else begin
      pin_s1 <= {boot_section_lock_setting, app_boot_lock_setting, boot_reset_fuse};
      pin_s2 <= pin_s1;
    end
  end

  logic fuse;
  logic lock_app;
  logic lock_boot;
  assign fuse      = pin_s2[0];
  assign lock_app  = pin_s2[1];
  assign lock_boot = pin_s2[2];

  ////////////////////////////////////////////////////////////////////////////
  // request selection

  logic [NT-1:0] req_vec;
  logic          any_req;
  logic [7:0]    sel_idx;
  logic          in_boot;
  logic          lock_block;
  logic          take;
  logic          entry_done;
  logic          ret_done;

  assign req_vec = {level_req & lvl_en, flag_pend & flag_en};

  // lowest index has the lowest vector and therefore wins
  always_comb begin
    any_req = 1'b0;
    sel_idx = 8'h00;
    for (int k = NT - 1; k >= 0; k--) begin
      if (req_vec[k]) begin
        any_req = 1'b1;
        sel_idx = 8'(k);
      end
    end
  end

  assign in_boot = core_pc >= BOOT_START;
  // a locked section may not be entered from the other one through a vector placed in it
  assign lock_block = (lock_app && !vector_table_select && in_boot) || (lock_boot && vector_table_select && !in_boot);

  // the core reports boundaries only after the whole instruction is done
  assign take = (st == ST_IDLE) && i_bit && any_req && !core.cli && !lock_block &&
                ((core.boundary && !skip) || core.sleeping);

  assign entry_done = (st == ST_ENTRY) && (cnt == ENTRY_CYC - 3'h1);
  assign ret_done   = (st == ST_RET) && (cnt == RET_CYC - 3'h1);

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: zero wait states, read data registered in the address phase

  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (haddr[7:0])
      OFS_CTRL: begin
        rd_mux[CTRL_GIE_BIT]   = i_bit;
        rd_mux[CTRL_VECTOR_TABLE_SELECT_BIT] = vector_table_select;
      end
      OFS_FLAG_EN:  rd_mux[NF-1:0] = flag_en;
      OFS_FLAG:     rd_mux[NF-1:0] = flag_pend;
      OFS_LEVEL_EN: rd_mux[NL-1:0] = lvl_en;
      OFS_LEVEL:    rd_mux[NL-1:0] = level_req;
      OFS_SP:       rd_mux[15:0]   = sp;
      OFS_STATUS: begin
        rd_mux[STAT_IDX_LSB +: 8]   = act_idx;
        rd_mux[STAT_STATE_LSB +: 3] = 3'(st);
        rd_mux[STAT_SKIP_BIT]       = skip;
        rd_mux[STAT_FUSE_BIT]       = fuse;
        rd_mux[STAT_LOCKA_BIT]      = lock_app;
        rd_mux[STAT_LOCKB_BIT]      = lock_boot;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  logic addr_ok;
  assign addr_ok = hsel && (htrans == HTRANS_NONSEQ || htrans[1]) && hready;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ph_wr     <= 1'b0;
      ph_addr   <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      ph_wr     <= addr_ok && hwrite;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addr_ok) begin
        ph_addr <= haddr[7:0];
      end
      if (addr_ok && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  logic wr_ctrl;
  logic wr_flag;
  assign wr_ctrl = ph_wr && (ph_addr == OFS_CTRL);
  assign wr_flag = ph_wr && (ph_addr == OFS_FLAG);

  ////////////////////////////////////////////////////////////////////////////
  // control and enable registers

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      vector_table_select   <= 1'b0;
      flag_en <= '0;
      lvl_en  <= '0;
    end else begin
      if (wr_ctrl) begin
        vector_table_select <= hwdata[CTRL_VECTOR_TABLE_SELECT_BIT];
      end
      if (ph_wr && ph_addr == OFS_FLAG_EN) begin
        flag_en <= hwdata[NF-1:0];
      end
      if (ph_wr && ph_addr == OFS_LEVEL_EN) begin
        lvl_en <= hwdata[NL-1:0];
      end
    end
  end

  // global enable: only this bit of the status register lives here, nothing is saved on entry
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      i_bit <= 1'b0;
    end else if (take) begin
      i_bit <= 1'b0;
    end else if (ret_done) begin
      i_bit <= 1'b1;
    end else if (core.cli) begin
      i_bit <= 1'b0;
    end else if (core.sei) begin
      i_bit <= 1'b1;
    end else if (wr_ctrl) begin
      i_bit <= hwdata[CTRL_GIE_BIT];
    end
  end

  // one instruction must complete after set-global or a return
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      skip <= 1'b0;
    end else if (core.sei || ret_done) begin
      skip <= 1'b1;
    end else if (core.boundary) begin
      skip <= 1'b0;
    end
  end

  // pending flags: a new event beats a clear in the same cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flag_pend <= '0;
    end else begin
      for (int k = 0; k < NF; k++) begin
        if (flag_evt[k]) begin
          flag_pend[k] <= 1'b1;
        end else if (entry_done && act_idx == 8'(k)) begin
          flag_pend[k] <= 1'b0;
        end else if (wr_flag && hwdata[k]) begin
          flag_pend[k] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stack pointer

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sp <= SP_RESET;
    end else if (entry_done) begin
      sp <= sp - 16'h0002;
    end else if (ret_done) begin
      sp <= sp + 16'h0002;
    end else if (ph_wr && ph_addr == OFS_SP) begin
      sp <= hwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing of reset, wake, entry, jump and return

  logic [15:0] vec_base;
  assign vec_base = vector_table_select ? BOOT_START : PC_RESET;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st        <= ST_RST;
      cnt       <= 3'h0;
      act_idx   <= 8'h00;
      ret_pc    <= 16'h0000;
      pop_hi    <= 8'h00;
      core_hold <= 1'b1;
      pc_load   <= 1'b0;
      pc_value  <= PC_RESET;
      stk       <= '0;
      wake_req  <= 1'b0;
      int_ack   <= 1'b0;
    end else begin
      pc_load  <= 1'b0;
      stk      <= '0;
      int_ack  <= 1'b0;
      case (st)
        ST_RST: begin
          // wait until the fuse strap has passed its synchroniser
          cnt <= cnt + 3'h1;
          if (cnt == RST_SETTLE - 3'h1) begin
            pc_load   <= 1'b1;
            pc_value  <= fuse ? BOOT_START : PC_RESET;
            core_hold <= 1'b0;
            cnt       <= 3'h0;
            st        <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          cnt <= 3'h0;
          if (take) begin
            act_idx   <= sel_idx;
            ret_pc    <= core_pc;
            int_ack   <= 1'b1;
            core_hold <= 1'b1;
            if (core.sleeping) begin
              wake_req <= 1'b1;
              st       <= ST_WAKE;
            end else begin
              st <= ST_ENTRY;
            end
          end else if (core.return_from_interrupt) begin
            core_hold <= 1'b1;
            st        <= ST_RET;
          end
        end
        ST_WAKE: begin
          // start-up time belongs to the core: count only once it is awake
          if (!core.sleeping) begin
            wake_req <= 1'b0;
            cnt      <= cnt + 3'h1;
            if (cnt == WAKE_EXTRA - 3'h1) begin
              cnt <= 3'h0;
              st  <= ST_ENTRY;
            end
          end
        end
        ST_ENTRY: begin
          cnt <= cnt + 3'h1;
          if (cnt == 3'h0) begin
            stk.we    <= 1'b1;
            stk.addr  <= sp;
            stk.wdata <= ret_pc[7:0];
          end else if (cnt == 3'h1) begin
            stk.we    <= 1'b1;
            stk.addr  <= sp - 16'h0001;
            stk.wdata <= ret_pc[15:8];
          end
          if (entry_done) begin
            pc_load   <= 1'b1;
            pc_value  <= vec_base + 16'(({8'h00, act_idx} + 16'h0001) * VEC_STRIDE);
            core_hold <= 1'b0;
            cnt       <= 3'h0;
            st        <= ST_JUMP;
          end
        end
        ST_JUMP: begin
          // the core runs the vector jump; no new service starts meanwhile
          cnt <= cnt + 3'h1;
          if (cnt == JUMP_CYC - 3'h1) begin
            cnt <= 3'h0;
            st  <= ST_IDLE;
          end
        end
        ST_RET: begin
          // sync stack memory: data appears the cycle after the read strobe
          cnt <= cnt + 3'h1;
          if (cnt == 3'h0) begin
            stk.re   <= 1'b1;
            stk.addr <= sp + 16'h0001;
          end else if (cnt == 3'h1) begin
            stk.re   <= 1'b1;
            stk.addr <= sp + 16'h0002;
          end else if (cnt == 3'h2) begin
            pop_hi <= stk_rdata;
          end
          if (ret_done) begin
            pc_load   <= 1'b1;
            pc_value  <= {pop_hi, stk_rdata};
            core_hold <= 1'b0;
            cnt       <= 3'h0;
            st        <= ST_IDLE;
          end
        end
        default: begin
          st <= ST_IDLE;
        end
      endcase
    end
  end

endmodule : cis_sequencer
`default_nettype wire

// ### cis_stack_model.sv
// behavioural stack ram standing at the sequencer's far side
`default_nettype none
module cis_stack_model
  import cis_pkg::*;
(
  input  wire logic          mclk,
  input  wire cis_pkg::cis_stk_t stk,
  output var  logic [7:0]    rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:255];
  initial rdata = 8'h00;
  always @(posedge mclk) begin
    if (stk.we) begin
      mem[stk.addr[7:0]] <= stk.wdata;
    end
    // no read: show a changing pattern, never a stale byte
    rdata <= stk.re ? mem[stk.addr[7:0]] : ~rdata;
  end
endmodule : cis_stack_model
`default_nettype wire

// ### cis_seq_checker.sv
// assertions on the sequencer's bus and core-side ports
`default_nettype none
module cis_seq_checker
  import cis_pkg::*;
(
  input wire logic          mclk,
  input wire logic          rst,
  input wire logic          hreadyout,
  input wire logic          hresp,
  input wire cis_pkg::cis_core_t core,
  input wire logic [7:0]    stk_rdata,
  input wire logic          core_hold,
  input wire logic          pc_load,
  input wire logic [15:0]   pc_value,
  input wire cis_pkg::cis_stk_t stk,
  input wire logic          wake_req,
  input wire logic          int_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  bus_ready_a: assert property (hreadyout) else $error("bus slave stalled");
  bus_okay_a: assert property (!hresp) else $error("bus error response");
  entry_walk_a: assert property (
    int_ack && !wake_req |=> stk.we ##1 stk.we ##1 !pc_load ##1 pc_load && !core_hold
  ) else $error("entry sequence wrong");
  push_down_a: assert property (
    int_ack && !wake_req |=> ##1 stk.we && stk.addr == $past(stk.addr) - 16'h0001
  ) else $error("push address not descending");
  ack_gap_a: assert property (
    int_ack |=> !int_ack [*6]
  ) else $error("second take during entry");
  ret_walk_a: assert property (
    core.return_from_interrupt && !core_hold |-> ##2 stk.re ##1 stk.re ##2 pc_load
  ) else $error("return sequence wrong");
  ret_up_a: assert property (
    core.return_from_interrupt && !core_hold |-> ##3 stk.addr == $past(stk.addr) + 16'h0001
  ) else $error("pop address not ascending");
  ret_pop_a: assert property (
    core.return_from_interrupt && !core_hold |-> ##5 pc_value == {$past(stk_rdata, 2), $past(stk_rdata, 1)}
  ) else $error("popped pc wrong");
  cli_block_a: assert property (
    core.boundary && core.cli |=> !int_ack ##1 !int_ack
  ) else $error("take in clear-global cycle");
  wake_delay_a: assert property (
    $fell(wake_req) |-> !pc_load [*6]
  ) else $error("wake entry too early");
endmodule : cis_seq_checker
bind cis_sequencer cis_seq_checker u_chk (.mclk(mclk), .rst(rst), .hreadyout(hreadyout), .hresp(hresp),
  .core(core), .stk_rdata(stk_rdata), .core_hold(core_hold), .pc_load(pc_load), .pc_value(pc_value),
  .stk(stk), .wake_req(wake_req), .int_ack(int_ack));
`default_nettype wire

// ### cis_sequencer_tb_top.sv
// self-checking bench of the interrupt sequencer
`default_nettype none
module cis_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cis_pkg::*;
  localparam int          NF   = 8;
  localparam logic [15:0] BOOT = 16'h7000;
  localparam logic [4:0]  B = 5'h10, C = 5'h08, S = 5'h04, R = 5'h02, SL = 5'h01;
  logic          mclk, rst, hsel, hwrite, hreadyout, hresp, fuse, pc_load, wake_req, int_ack, core_hold;
  logic [31:0]   haddr, hwdata, hrdata;
  logic [1:0]    htrans;
  logic [15:0]   pc_value, cpc;
  logic          lock_a, lock_b;
  logic [7:0]    rdata;
  logic [NF-1:0] flag_evt;
  logic [3:0]    level_req;
  cis_core_t     core;
  cis_stk_t      stk;
  int            n_fail, checks, n_ack, last_wait;

  cis_sequencer #(.NF(NF), .NL(4), .BOOT_START(BOOT)) dut (.mclk(mclk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .flag_evt(flag_evt), .level_req(level_req),
    .boot_reset_fuse(fuse), .app_boot_lock_setting(lock_a), .boot_section_lock_setting(lock_b),
    .core(core), .core_pc(cpc), .stk_rdata(rdata), .core_hold(core_hold), .pc_load(pc_load),
    .pc_value(pc_value), .stk(stk), .wake_req(wake_req), .int_ack(int_ack));
  cis_stack_model u_stk (.mclk(mclk), .stk(stk), .rdata(rdata));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) if (int_ack === 1'b1) n_ack++;

  ////////////////////////////////////////////////////////////////
  task wrap_up;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task hrdy;
    int i;
    i = 0;
    do begin @(posedge mclk); i++; end while (hreadyout !== 1'b1 && i < 50);
    if (hreadyout !== 1'b1) begin n_fail++; wrap_up; end
  endtask : hrdy
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    hsel <= 1'b1; htrans <= HTRANS_NONSEQ; hwrite <= w; haddr <= {24'h0, a};
    hrdy;
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    hrdy;
    q = hrdata;
  endtask : bus
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rd
  // one instruction completes at the second edge; three edges let the ack land
  task ins(input logic [4:0] v);
    @(posedge mclk) core <= v;
    @(posedge mclk) core <= 5'h00;
    repeat (3) @(posedge mclk);
  endtask : ins
  task evt(input logic [NF-1:0] f);
    @(posedge mclk) flag_evt <= f;
    @(posedge mclk) flag_evt <= '0;
  endtask : evt
  task wpc(input logic [15:0] exp);
    last_wait = 0;
    do begin @(posedge mclk); last_wait++; end while (pc_load !== 1'b1 && last_wait < 40);
    if (pc_load !== 1'b1) begin n_fail++; wrap_up; end
    chk(32'(pc_value), 32'(exp));
  endtask : wpc

  ////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1; hsel = 1'b0; hwrite = 1'b0; haddr = '0; hwdata = '0; htrans = 2'h0; fuse = 1'b0;
    core = '0; flag_evt = '0; level_req = '0; n_fail = 0; checks = 0; n_ack = 0;
    lock_a = 1'b0; lock_b = 1'b0; cpc = 16'h1234;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    wpc(PC_RESET);
    rd(OFS_SP, 32'(SP_RESET));
    rd(8'h1c, 32'h0);
    wr(OFS_SP, 32'h100);
    evt(8'h05);
    rd(OFS_FLAG, 32'h5);
    wr(OFS_FLAG, 32'h0);
    rd(OFS_FLAG, 32'h5);
    wr(OFS_FLAG_EN, 32'h5);
    ins(B);
    chk(32'(n_ack), 32'h0);
    wr(OFS_CTRL, 32'h1);
    ins(B);
    wpc(VEC_STRIDE);
    rd(OFS_CTRL, 32'h0);
    rd(OFS_FLAG, 32'h4);
    rd(OFS_SP, 32'hfe);
    ins(R);
    wpc(16'h1234);
    rd(OFS_SP, 32'h100);
    rd(OFS_CTRL, 32'h1);
    ins(B);
    chk(32'(n_ack), 32'h1);
    ins(B);
    wpc(VEC_STRIDE * 16'h3);
    evt(8'h01);
    ins(S | B);
    ins(B);
    chk(32'(n_ack), 32'h2);
    ins(B);
    wpc(VEC_STRIDE);
    ins(S | B);
    ins(B);
    evt(8'h01);
    ins(C | B);
    chk(32'(n_ack), 32'h3);
    rd(OFS_CTRL, 32'h0);
    wr(OFS_FLAG, 32'h1);
    @(posedge mclk) level_req <= 4'h1;
    @(posedge mclk) level_req <= 4'h0;
    wr(OFS_LEVEL_EN, 32'h1);
    wr(OFS_CTRL, 32'h3);
    ins(B);
    chk(32'(n_ack), 32'h3);
    @(posedge mclk) level_req <= 4'h1;
    ins(B);
    wpc(BOOT + VEC_STRIDE * 16'(NF + 1));
    level_req <= 4'h0;
    ins(S | B);
    ins(B);
    @(posedge mclk) core <= SL;
    evt(8'h01);
    repeat (3) @(posedge mclk);
    chk(32'(wake_req), 32'h1);
    core <= 5'h00;
    wpc(BOOT + VEC_STRIDE);
    chk(32'(last_wait >= 8), 32'h1);
    fuse <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b1;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    wpc(BOOT);
    // app lock with vectors in app: blocked while the pc sits in the boot section only
    lock_a <= 1'b1;
    cpc <= BOOT;
    wr(OFS_FLAG_EN, 32'h1);
    wr(OFS_CTRL, 32'h1);
    evt(8'h01);
    ins(B);
    chk(32'(n_ack), 32'h5);
    cpc <= 16'h1234;
    ins(B);
    wpc(VEC_STRIDE);
    // boot lock with vectors in boot: blocked while the pc sits in the app section
    lock_b <= 1'b1;
    wr(OFS_CTRL, 32'h3);
    evt(8'h01);
    ins(B);
    chk(32'(n_ack), 32'h6);
    wrap_up;
  end
endmodule : cis_sequencer_tb_top
`default_nettype wire
